// ### design/shrp_serial_port.v
`timescale 1ns/100ps
`include "shrp_regs.vh"

// Functional notes
// - Data changes low clock; start, stop decoded
// - First byte: seven-bit address plus direction
// - Matching address acknowledged on ninth clock
// - Bytes shifted eight bits, MSB first
// - Receiver acknowledges each byte, ninth clock
// - Address upper fixed, two low from straps
// - Write byte after address sets pointer
// - Write data stores, pointer increments
// - Identity registers fixed, writes ignored
// - Upper frequency bytes buffered until byte0
// - Lock enable and reference rate select
// - Luma delay select control
// - Test ramp replaces normal video
// - Separate and composite outputs disable
// - Two-bit video standard field
// - Pin disables combine with direction bits
// - Pin0 input, port output, or sync
// - Chroma bandwidth select control
// - Sync pulses replaced by blanking level
// - Luma, chroma, burst disable controls
// - Setup only on active line ranges
// - Not-locked flag reads one unlocked
// - 23-cell scan chain, TDO on falling
module shrp_serial_port (
  input wire clk_i,
  input wire rst_n_i,
  input wire scl_i,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe_o,
  input wire addr_strap_low_i,
  input wire addr_strap_high_i,
  input wire not_locked_i,
  input wire [2:0] field_num_i,
  input wire composite_sync_in_i,
  input wire clamp_gate_in_i,
  input wire [7:0] port_pin_i,
  output reg [7:0] port_pin_o,
  output reg [7:0] port_pin_oe_o,
  output reg [7:0] global_control_o,
  output reg [7:0] video_output_control_o,
  output reg [2:0] anc_enables_o,
  output reg [7:0] anc_packet_id_o,
  output reg [31:0] carrier_freq_o,
  output reg [15:0] carrier_phase_o,
  input wire reset_pin_i,
  input wire pixel_clock_in_i,
  input wire [7:0] pixel_data_i,
  input wire carrier_ref_in_i,
  input wire tck_i,
  input wire tms_i,
  input wire tdi_i,
  output reg tdo_o
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  reg [1:0] scl_sync_reg; // Serial clock, two stages
  reg [1:0] sda_sync_reg; // Serial data, two stages
  reg [1:0] tck_sync_reg; // Scan clock
  reg [1:0] tms_sync_reg;
  reg [1:0] tdi_sync_reg;
  reg [7:0] pin_s1_reg; // Port pins, first stage
  reg [7:0] pin_s2_reg;
  reg [1:0] strap0_reg;
  reg [1:0] strap1_reg;
  reg scl_d_reg; // Delayed synced levels for edges
  reg sda_d_reg;
  reg tck_d_reg;
  reg [21:0] scan_sync_reg; // Scan-only pins, two stages of eleven

  // Only the second stage is read by logic
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      tck_sync_reg <= 2'h0;
      tms_sync_reg <= 2'h0;
      tdi_sync_reg <= 2'h0;
      pin_s1_reg <= 8'h00;
      pin_s2_reg <= 8'h00;
      strap0_reg <= 2'h0;
      strap1_reg <= 2'h0;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      tck_d_reg <= 1'b0;
      scan_sync_reg <= 22'h0;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_i};
      sda_sync_reg <= {sda_sync_reg[0], sda_i};
      tck_sync_reg <= {tck_sync_reg[0], tck_i};
      tms_sync_reg <= {tms_sync_reg[0], tms_i};
      tdi_sync_reg <= {tdi_sync_reg[0], tdi_i};
      pin_s1_reg <= port_pin_i;
      pin_s2_reg <= pin_s1_reg;
      strap0_reg <= {strap0_reg[0], addr_strap_low_i};
      strap1_reg <= {strap1_reg[0], addr_strap_high_i};
      scl_d_reg <= scl_sync_reg[1];
      sda_d_reg <= sda_sync_reg[1];
      tck_d_reg <= tck_sync_reg[1];
      scan_sync_reg <= {scan_sync_reg[10:0], reset_pin_i, pixel_clock_in_i, pixel_data_i, carrier_ref_in_i};
    end
  end

  wire scl_s = scl_sync_reg[1];
  wire sda_s = sda_sync_reg[1];
  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;
  // Start and stop: data edge while clock stays high
  wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  // Own address: fixed upper bits, straps below
  wire [6:0] own_addr = {`SHRP_ADDR_UPPER, strap1_reg[1], strap0_reg[1]};

  // ----------------------------------------
  // Serial state machine
  // ----------------------------------------
  localparam [4:0] ST_IDLE = 5'h01; // Bus free or not addressed
  localparam [4:0] ST_ADDR = 5'h02; // Receiving slave address
  localparam [4:0] ST_RX = 5'h04; // Receiving pointer or data
  localparam [4:0] ST_TX = 5'h08; // Sending read data
  localparam [4:0] ST_ACK = 5'h10; // Ninth clock phase

  reg [4:0] state_reg;
  reg [3:0] bit_cnt_reg; // Bits seen in this byte
  reg [7:0] shift_reg; // Receive and transmit shifter
  reg [7:0] pointer_reg; // Register pointer
  reg have_ptr_reg; // Pointer byte already taken
  reg read_dir_reg; // Transaction is a read
  reg master_nack_reg; // Master released line on read ack
  reg after_ack_reg; // Which state follows the ninth clock

  // Register storage
  reg [7:0] global_reg;
  reg [7:0] video_out_reg;
  reg [7:0] anc_ctrl_reg;
  reg [7:0] anc_id_reg;
  reg [23:0] freq_buf_reg; // Pending upper frequency bytes
  reg [31:0] freq_reg; // Active frequency
  reg [15:0] phase_reg;
  reg [7:0] port_data_reg;
  reg [7:0] port_dir_reg;

  // Read mux of the register file
  reg [7:0] rd_data;
  always @* begin
    case (pointer_reg)
      `SHRP_OFF_PART_UPPER: rd_data = `SHRP_PART_UPPER;
      `SHRP_OFF_PART_MIDDLE: rd_data = `SHRP_PART_MIDDLE;
      `SHRP_OFF_PART_LOWER: rd_data = `SHRP_PART_LOWER;
      `SHRP_OFF_REVISION: rd_data = `SHRP_REVISION;
      `SHRP_OFF_GLOBAL: rd_data = global_reg;
      `SHRP_OFF_VIDEO_OUT: rd_data = video_out_reg;
      // Lock flag live, field number from video timing
      `SHRP_OFF_ANC_CTRL: rd_data = {1'b0, not_locked_i, field_num_i, anc_ctrl_reg[2:0]};
      `SHRP_OFF_ANC_ID: rd_data = anc_id_reg;
      // Buffered bytes read back as last written
      `SHRP_OFF_FREQ3: rd_data = freq_buf_reg[23:16];
      `SHRP_OFF_FREQ2: rd_data = freq_buf_reg[15:8];
      `SHRP_OFF_FREQ1: rd_data = freq_buf_reg[7:0];
      `SHRP_OFF_FREQ0: rd_data = freq_reg[7:0];
      `SHRP_OFF_PHASE_HI: rd_data = phase_reg[15:8];
      `SHRP_OFF_PHASE_LO: rd_data = phase_reg[7:0];
      // Input pins read the pin level, outputs the stored bit
      `SHRP_OFF_PORT_DATA: rd_data = (pin_s2_reg & ~port_dir_reg) | (port_data_reg & port_dir_reg);
      `SHRP_OFF_PORT_DIR: rd_data = port_dir_reg;
      default: rd_data = 8'h00; // Reserved space reads zero
    endcase
  end

  // Write strobe from a completed received data byte
  wire wr_en = state_reg[2] & scl_fall & (bit_cnt_reg == 4'd8) & have_ptr_reg;

  // Main protocol process
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      pointer_reg <= 8'h00;
      have_ptr_reg <= 1'b0;
      read_dir_reg <= 1'b0;
      master_nack_reg <= 1'b0;
      after_ack_reg <= 1'b0;
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
    end else if (start_det) begin
      // Start or repeated start always restarts addressing
      state_reg <= ST_ADDR;
      bit_cnt_reg <= 4'h0;
      have_ptr_reg <= 1'b0;
      sda_oe_o <= 1'b0;
    end else if (stop_det) begin
      state_reg <= ST_IDLE;
      sda_oe_o <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          sda_oe_o <= 1'b0;
        end
        ST_ADDR, ST_RX: begin
          // Sample on rising clock, MSB first
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'd1;
          end
          if (scl_fall && bit_cnt_reg == 4'd8) begin
            bit_cnt_reg <= 4'h0;
            if (state_reg == ST_ADDR) begin
              // Address then direction bit, high means read
              if (shift_reg[7:1] == own_addr) begin
                read_dir_reg <= shift_reg[0];
                sda_oe_o <= 1'b1;
                after_ack_reg <= shift_reg[0];
                state_reg <= ST_ACK;
              end else begin
                state_reg <= ST_IDLE; // Line stays released
              end
            end else begin
              // First byte is the pointer then data
              if (!have_ptr_reg) begin
                pointer_reg <= shift_reg;
                have_ptr_reg <= 1'b1;
              end else begin
                pointer_reg <= pointer_reg + 8'd1;
              end
              sda_oe_o <= 1'b1; // Device acks received byte
              after_ack_reg <= 1'b0;
              state_reg <= ST_ACK;
            end
          end
        end
        ST_ACK: begin
          // Sample master ack on a read's ninth clock
          if (scl_rise && read_dir_reg && !sda_oe_o) begin
            master_nack_reg <= sda_s;
          end
          if (scl_fall) begin
            if (after_ack_reg && !(read_dir_reg && !sda_oe_o && master_nack_reg)) begin
              // Load byte at pointer, drive MSB
              shift_reg <= {rd_data[6:0], 1'b0};
              sda_o <= 1'b0;
              sda_oe_o <= ~rd_data[7]; // Open drain: drive only zeros
              bit_cnt_reg <= 4'd1;
              state_reg <= ST_TX;
            end else if (after_ack_reg) begin
              sda_oe_o <= 1'b0; // Master refused, wait for stop
              state_reg <= ST_IDLE;
            end else begin
              sda_oe_o <= 1'b0;
              bit_cnt_reg <= 4'h0;
              state_reg <= ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_reg == 4'd8) begin
              // Release for master's acknowledge
              sda_oe_o <= 1'b0;
              master_nack_reg <= 1'b1;
              pointer_reg <= pointer_reg + 8'd1;
              after_ack_reg <= 1'b1;
              state_reg <= ST_ACK;
            end else begin
              sda_oe_o <= ~shift_reg[7];
              shift_reg <= {shift_reg[6:0], 1'b0};
              bit_cnt_reg <= bit_cnt_reg + 4'd1;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  wire [7:0] wr_addr = pointer_reg;
  wire [7:0] wr_data = shift_reg;

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      global_reg <= `SHRP_RST_ZERO;
      video_out_reg <= `SHRP_RST_ZERO;
      anc_ctrl_reg <= `SHRP_RST_ZERO;
      anc_id_reg <= `SHRP_RST_ZERO;
      freq_buf_reg <= {`SHRP_RST_FREQ3, `SHRP_RST_FREQ2, `SHRP_RST_FREQ1};
      freq_reg <= {`SHRP_RST_FREQ3, `SHRP_RST_FREQ2, `SHRP_RST_FREQ1, `SHRP_RST_FREQ0};
      phase_reg <= 16'h0000;
      port_data_reg <= `SHRP_RST_ZERO;
      port_dir_reg <= `SHRP_RST_ZERO;
    end else if (wr_en) begin
      // Identity offsets have no case item: writes ignored
      case (wr_addr)
        `SHRP_OFF_GLOBAL: global_reg <= wr_data;
        `SHRP_OFF_VIDEO_OUT: video_out_reg <= wr_data;
        `SHRP_OFF_ANC_CTRL: anc_ctrl_reg <= wr_data & `SHRP_ANC_WMASK;
        `SHRP_OFF_ANC_ID: anc_id_reg <= wr_data;
        `SHRP_OFF_FREQ3: freq_buf_reg[23:16] <= wr_data;
        `SHRP_OFF_FREQ2: freq_buf_reg[15:8] <= wr_data;
        `SHRP_OFF_FREQ1: freq_buf_reg[7:0] <= wr_data;
        `SHRP_OFF_FREQ0: freq_reg <= {freq_buf_reg, wr_data};
        `SHRP_OFF_PHASE_HI: phase_reg[15:8] <= wr_data;
        `SHRP_OFF_PHASE_LO: phase_reg[7:0] <= wr_data;
        `SHRP_OFF_PORT_DATA: port_data_reg <= wr_data;
        `SHRP_OFF_PORT_DIR: port_dir_reg <= wr_data;
        default: port_dir_reg <= port_dir_reg; // Reserved: no effect
      endcase
    end
  end

  // ----------------------------------------
  // Control outputs and port pins
  // ----------------------------------------
  // Video path consumes these bits; registered copies
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      global_control_o <= 8'h00;
      video_output_control_o <= 8'h00;
      anc_enables_o <= 3'h0;
      anc_packet_id_o <= 8'h00;
      carrier_freq_o <= {`SHRP_RST_FREQ3, `SHRP_RST_FREQ2, `SHRP_RST_FREQ1, `SHRP_RST_FREQ0};
      carrier_phase_o <= 16'h0000;
    end else begin
      // Lock, ref rate luma delay ramp
      // output disables standard
      global_control_o <= global_reg;
      // Bandwidth sync blanking input disables setup
      video_output_control_o <= video_out_reg;
      anc_enables_o <= anc_ctrl_reg[2:0];
      anc_packet_id_o <= anc_id_reg;
      carrier_freq_o <= freq_reg;
      carrier_phase_o <= phase_reg;
    end
  end

  // Pins 0 and 1 pick port bit or timing output
  reg [7:0] pin_val;
  always @* begin
    pin_val = port_data_reg;
    if (!video_out_reg[`SHRP_VO_SYNCPIN]) begin
      pin_val[0] = composite_sync_in_i; // Port write no effect
    end
    if (!video_out_reg[`SHRP_VO_CLAMPPIN]) begin
      pin_val[1] = clamp_gate_in_i;
    end
  end

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      port_pin_o <= 8'h00;
      port_pin_oe_o <= 8'h00;
    end else begin
      port_pin_o <= pin_val;
      port_pin_oe_o <= port_dir_reg; // Low direction means input
    end
  end

  // ----------------------------------------
  // Boundary scan chain
  // ----------------------------------------
  wire tck_rise = tck_sync_reg[1] & ~tck_d_reg;
  wire tck_fall = ~tck_sync_reg[1] & tck_d_reg;
  // Capture order, first cell first
  wire [`SHRP_SCAN_LEN-1:0] scan_pins = {scan_sync_reg[21:12],
    strap1_reg[1], strap0_reg[1], sda_s, scl_s, scan_sync_reg[11], pin_s2_reg};
  reg [`SHRP_SCAN_LEN-1:0] scan_reg;

  // Simplified: tms high captures, low shifts
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      scan_reg <= {`SHRP_SCAN_LEN{1'b0}};
      tdo_o <= 1'b0;
    end else begin
      if (tck_rise) begin
        if (tms_sync_reg[1]) begin
          scan_reg <= scan_pins;
        end else begin
          scan_reg <= {scan_reg[`SHRP_SCAN_LEN-2:0], tdi_sync_reg[1]};
        end
      end
      if (tck_fall) begin
        tdo_o <= scan_reg[`SHRP_SCAN_LEN-1];
      end
    end
  end

endmodule // shrp_serial_port

// ### pkg/shrp_regs.vh
`ifndef SHRP_REGS_VH
`define SHRP_REGS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SHRP_OFF_PART_UPPER 8'h00
`define SHRP_OFF_PART_MIDDLE 8'h01
`define SHRP_OFF_PART_LOWER 8'h02
`define SHRP_OFF_REVISION 8'h03
`define SHRP_OFF_GLOBAL 8'h04
`define SHRP_OFF_VIDEO_OUT 8'h05
`define SHRP_OFF_ANC_CTRL 8'h06
`define SHRP_OFF_ANC_ID 8'h07
`define SHRP_OFF_FREQ3 8'h08
`define SHRP_OFF_FREQ2 8'h09
`define SHRP_OFF_FREQ1 8'h0a
`define SHRP_OFF_FREQ0 8'h0b
`define SHRP_OFF_PHASE_HI 8'h0c
`define SHRP_OFF_PHASE_LO 8'h0d
`define SHRP_OFF_PORT_DATA 8'h0e
`define SHRP_OFF_PORT_DIR 8'h0f
// ----------------------------------------
// Identity values (arbitrary neutral values)
// ----------------------------------------
`define SHRP_PART_UPPER 8'h5a
`define SHRP_PART_MIDDLE 8'h3c
`define SHRP_PART_LOWER 8'h12
`define SHRP_REVISION 8'h07
// ----------------------------------------
// Reset values
// ----------------------------------------
`define SHRP_RST_ZERO 8'h00
`define SHRP_RST_FREQ3 8'h43
`define SHRP_RST_FREQ2 8'he0
`define SHRP_RST_FREQ1 8'hf8
`define SHRP_RST_FREQ0 8'h3e
// ----------------------------------------
// Slave address and field positions
// ----------------------------------------
`define SHRP_ADDR_UPPER 5'h03
`define SHRP_GC_REF4 7
`define SHRP_GC_LOCK 6
`define SHRP_GC_LDLY 5
`define SHRP_GC_RAMP 4
`define SHRP_GC_SEPDIS 3
`define SHRP_GC_COMPDIS 2
`define SHRP_VO_SYNCPIN 7
`define SHRP_VO_CLAMPPIN 6
`define SHRP_VO_CBW 5
`define SHRP_VO_SYNCPULSE 4
`define SHRP_VO_BURST 3
`define SHRP_VO_LUMA 2
`define SHRP_VO_CHROMA 1
`define SHRP_VO_SETUP 0
`define SHRP_ANC_NOLOCK 6
`define SHRP_ANC_WMASK 8'h0f
`define SHRP_SCAN_LEN 23
`endif

// ### sim/shrp_host_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Serial bus master, 125 ns bit period
// ----------------------------------------
module shrp_host_model (
  input wire clk_i,
  input wire sda_i,
  output reg scl_o,
  output reg sda_pull_o
);
  // Bus idles free: clock high, data released
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  task q(input integer n);
    repeat (n) @(posedge clk_i);
  endtask
  // Data set mid low phase, sampled late in high phase
  task bit_io(input logic b, output logic s);
    sda_pull_o <= ~b;
    q(6);
    scl_o <= 1'b1;
    q(13);
    s = sda_i;
    scl_o <= 1'b0;
    q(6);
  endtask
  // Data falls with clock high
  task start_c;
    sda_pull_o <= 1'b0;
    q(6);
    scl_o <= 1'b1;
    q(6);
    sda_pull_o <= 1'b1;
    q(6);
    scl_o <= 1'b0;
    q(6);
  endtask
  // Data rises with clock high; clock then stands still
  task stop_c;
    sda_pull_o <= 1'b1;
    q(6);
    scl_o <= 1'b1;
    q(6);
    sda_pull_o <= 1'b0;
    q(6);
  endtask
  // Eight bits MSB first, then sample acknowledge
  task byte_tx(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  // Receive MSB first, then ack or final nack
  task byte_rx(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(nack, s);
  endtask
endmodule // shrp_host_model

// ### sim/shrp_serial_port_asserts.sv
`timescale 1ns/100ps
// ----------------------------------------
// Checker on the serial register port pins
// ----------------------------------------
module shrp_port_checker (
  input wire clk_i,
  input wire rst_n_i,
  input wire scl_i,
  input wire sda_o,
  input wire sda_oe_o,
  input wire composite_sync_in_i,
  input wire clamp_gate_in_i,
  input wire [7:0] port_pin_o,
  input wire [7:0] port_pin_oe_o,
  input wire [7:0] global_control_o,
  input wire [7:0] video_output_control_o,
  input wire [31:0] carrier_freq_o,
  input wire tck_i,
  input wire tdo_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Open drain: only ever pulls low
  sda_pull_only_a: assert property (sda_o == 1'b0)
    else $error("data line driven high");
  // Answer bits move only while the serial clock is low
  sda_low_clk_a: assert property ($changed(sda_oe_o) |-> !scl_i && !$past(scl_i))
    else $error("data drive changed with clock high");
  // A driven low bit stands for at least the next eight cycles
  ack_hold_a: assert property ($rose(sda_oe_o) |=> sda_oe_o [*8])
    else $error("driven bit released early");
  // Register write is acknowledged within a few cycles
  write_ack_a: assert property ($changed(global_control_o) |-> ##[0:4] sda_oe_o)
    else $error("control changed without acknowledge");
  // Frequency only moves at byte boundaries, clock low
  freq_low_clk_a: assert property ($changed(carrier_freq_o) |-> !scl_i)
    else $error("frequency changed with clock high");
  freq_reset_a: assert property ($rose(rst_n_i) |-> carrier_freq_o == 32'h43e0f83e)
    else $error("frequency reset value wrong");
  // Pins 0 and 1 follow timing signals when not disabled
  pin0_sync_a: assert property ((port_pin_oe_o[0] && !video_output_control_o[7] &&
    $stable(composite_sync_in_i)) [*2] |-> port_pin_o[0] == composite_sync_in_i)
    else $error("pin 0 does not carry composite sync");
  pin1_clamp_a: assert property ((port_pin_oe_o[1] && !video_output_control_o[6] &&
    $stable(clamp_gate_in_i)) [*2] |-> port_pin_o[1] == clamp_gate_in_i)
    else $error("pin 1 does not carry clamp gate");
  // Scan output changes only after a falling test clock
  tdo_fall_a: assert property ($changed(tdo_o) |-> !tck_i && !$past(tck_i))
    else $error("scan output changed with test clock high");
endmodule // shrp_port_checker

bind shrp_serial_port shrp_port_checker u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .composite_sync_in_i(composite_sync_in_i),
  .clamp_gate_in_i(clamp_gate_in_i), .port_pin_o(port_pin_o), .port_pin_oe_o(port_pin_oe_o),
  .global_control_o(global_control_o), .video_output_control_o(video_output_control_o),
  .carrier_freq_o(carrier_freq_o), .tck_i(tck_i), .tdo_o(tdo_o));

// ### sim/testbench.sv
`timescale 1ns/100ps
`include "shrp_regs.vh"
// ----------------------------------------
// Bench for the serial register port
// ----------------------------------------
module testbench;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  wire scl, m_pull, sda_line;
  wire sda_o, sda_oe_o, tdo_o;
  logic sh = 1'b1, sl = 1'b0, nlk = 1'b0, cs = 1'b0, cg = 1'b0;
  logic rp = 1'b0, pck = 1'b0, ref_in = 1'b0, tck = 1'b0, tms = 1'b0, tdi = 1'b0;
  logic [2:0] fld = 3'h0;
  logic [7:0] pins = 8'h00, pd = 8'h00;
  wire [7:0] pin_o, pin_oe, gc, vo, part_code;
  wire [2:0] anc;
  wire [31:0] freq;
  wire [15:0] ph;
  integer num_errors = 0, cmp_count = 0, i, j;
  logic a;
  logic [7:0] d;
  // Pull-up wire: low if either side pulls
  assign sda_line = !(m_pull || (sda_oe_o && !sda_o));
  // Pins the design drives show its value
  wire [7:0] pin_lvl = (pin_oe & pin_o) | (~pin_oe & pins);
  // Expected capture, first cell first out
  wire [22:0] vec = {rp, pck, pd, sh, sl, 1'b1, 1'b1, ref_in, 8'hc5};
  always #2.5 clk_i = ~clk_i;
  shrp_host_model mst (.clk_i(clk_i), .sda_i(sda_line), .scl_o(scl), .sda_pull_o(m_pull));
  shrp_serial_port dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .addr_strap_low_i(sl), .addr_strap_high_i(sh), .not_locked_i(nlk), .field_num_i(fld),
    .composite_sync_in_i(cs), .clamp_gate_in_i(cg), .port_pin_i(pin_lvl), .port_pin_o(pin_o),
    .port_pin_oe_o(pin_oe), .global_control_o(gc), .video_output_control_o(vo), .anc_enables_o(anc),
    .anc_packet_id_o(part_code), .carrier_freq_o(freq), .carrier_phase_o(ph), .reset_pin_i(rp),
    .pixel_clock_in_i(pck), .pixel_data_i(pd), .carrier_ref_in_i(ref_in), .tck_i(tck), .tms_i(tms),
    .tdi_i(tdi), .tdo_o(tdo_o));
  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count = cmp_count + 1;
    if (g !== e) begin
      num_errors = num_errors + 1;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk_i);
  endtask
  // Start plus address byte, acknowledge compared
  task sel(input logic [1:0] lo, input logic rw, input logic ok);
    mst.start_c();
    mst.byte_tx({`SHRP_ADDR_UPPER, lo, rw}, a);
    chk(a, ok); // Address ack
  endtask
  // Pointer then n bytes taken from the top of v
  task wr(input logic [7:0] p, input logic [63:0] v, input integer n);
    sel({sh, sl}, 1'b0, 1'b1);
    mst.byte_tx(p, a);
    chk(a, 1'b1); // Pointer ack
    for (i = 0; i < n; i++) begin
      mst.byte_tx(v[63-8*i -: 8], a);
      chk(a, 1'b1); // Data ack
    end
    mst.stop_c();
  endtask
  // Set pointer, stop, then read n bytes
  task rd(input logic [7:0] p, input logic [63:0] v, input integer n);
    wr(p, 64'h0, 0); // Pointer only
    sel({sh, sl}, 1'b1, 1'b1);
    for (i = 0; i < n; i++) begin
      mst.byte_rx(i == n - 1, d);
      chk(d, v[63-8*i -: 8]); // Read data
    end
    mst.stop_c();
  endtask
  task print_verdict;
    $display("Comparisons %0d, errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Watchdog well beyond the expected run
  initial begin
    cyc(90000);
    num_errors = num_errors + 1;
    print_verdict;
  end
  initial begin
    cyc(12);
    rst_n_i <= 1'b1;
    cyc(6);
    chk(freq, 32'h43e0f83e); // Reset value
    chk({gc, vo, pin_oe}, 24'h0); // Reset values
    // Every strap setting: own address acked, another refused
    for (j = 0; j < 4; j++) begin
      @(posedge clk_i);
      {sh, sl} <= j[1:0];
      cyc(4);
      sel(j[1:0], 1'b0, 1'b1); // Match
      mst.stop_c();
      sel(~j[1:0], 1'b0, 1'b0); // Mismatch
      mst.stop_c();
    end
    // Burst over identity registers into control
    wr(8'h00, 64'hffffffffa51a059c, 8); // Auto increment
    chk(gc, 8'ha5); // Control
    chk({vo, 5'h0, anc, part_code}, 24'h1a059c); // Output control
    @(posedge clk_i);
    nlk <= 1'b1;
    fld <= 3'h6;
    rd(8'h00, {`SHRP_PART_UPPER, `SHRP_PART_MIDDLE, `SHRP_PART_LOWER, `SHRP_REVISION,
      32'ha51a759c}, 8); // Fixed identity and status
    // All four video standard codes, other bits inverted
    for (j = 0; j < 4; j++) begin
      wr(8'h04, {6'h16, j[1:0], 56'h0}, 1);
      chk(gc, {6'h16, j[1:0]}); // Standard code
    end
    // Upper frequency bytes wait for the low byte
    wr(8'h08, {24'h112233, 40'h0}, 3);
    chk(freq, 32'h43e0f83e); // Buffered
    wr(8'h0b, {24'h44c3d2, 40'h0}, 3);
    chk(freq, 32'h11223344); // Transferred
    chk(ph, 16'hc3d2); // Phase
    rd(8'h08, {32'h11223344, 32'h0}, 4); // Read back
    wr(8'h20, {8'h77, 56'h0}, 1);
    rd(8'h20, 64'h0, 1); // Reserved reads zero
    // Pins 0 and 1 as timing outputs, then as port outputs
    @(posedge clk_i);
    pins <= 8'hc4;
    cs <= 1'b1;
    wr(8'h0e, {16'h0103, 48'h0}, 2);
    chk(pin_oe, 8'h03); // Direction
    chk(pin_o[1:0], {cg, cs}); // Timing outputs
    @(posedge clk_i);
    cs <= 1'b0;
    cg <= 1'b1;
    cyc(4);
    chk(pin_o[1:0], {cg, cs}); // Timing outputs
    rd(8'h0e, {8'hc5, 56'h0}, 1); // Inputs read pins
    wr(8'h05, {8'hda, 56'h0}, 1);
    chk(pin_o[1:0], 2'b01); // Port data out
    // Capture, then shift the chain and a tdi pattern through
    @(posedge clk_i);
    rp <= 1'b1;
    pck <= 1'b1;
    pd <= 8'h96;
    ref_in <= 1'b1;
    cyc(4);
    for (j = 0; j < 46; j++) begin
      @(posedge clk_i);
      tms <= (j == 0);
      tdi <= (j % 3 == 0);
      cyc(8);
      tck <= 1'b1;
      cyc(8);
      tck <= 1'b0;
      cyc(8);
      if (j < 23)
        chk(tdo_o, vec[22-j]); // Chain order
      else
        chk(tdo_o, (j - 22) % 3 == 0); // Chain length
    end
    print_verdict;
  end
endmodule // testbench
